// [wdf_pkg.sv]
// Notes on behaviour
// - Down-counter underflow with reset enabled raises a system reset.
// - The power-on reset and the watchdog's own reset both return the watchdog to its initial state.
// - After any reset the timer runs, whatever the reset enable.
// - Control bit 2 starts (1) or stops (0) the timer; reads 1 after reset.
// - A 13-bit prescaler tap decrements an 8-bit down counter.
// - Control bit 0 picks the watchdog oscillator (1) or peripheral clock (0).
// - Reset enable low: no underflow reset, safety ignored, timer with interrupts.
// - Reset and safety enables high: clock and run forced, single writes only.
// - Control and load writes are staged, committed at feed completion.
// - A wrong feed sequence gives an immediate watchdog reset.
// - In watchdog mode a control write must be followed straight by a feed.
// - In timer mode control commits every cycle; a new counter load takes effect at a feed or at the next underflow.
// - Timeout is 2^(5+tap) times (load+1) plus one watchdog clocks.
// - Timeout flag bit 1 sets on underflow, clears by a feed in watchdog mode or written 0.
// - Control bits 7 to 5 pick the prescaler tap.
// - In timer mode underflow requests an interrupt when enabled.
// - A watchdog reset acts like power-on and clears power-on and brown-out flags.
// - Crystal select high clocks the prescaler from the crystal regardless.
// - New clock source takes effect after a feed: two old, two new ticks.
// - In timer mode underflow reloads the counter and counting continues.
// - In timer mode a wrong feed sequence is ignored.
package wdf_pkg;
	// Special function register addresses
	localparam logic [7:0] WDF_ADDR_CTRL = 8'ha7;
	localparam logic [7:0] WDF_ADDR_LOAD = 8'hc1;
	localparam logic [7:0] WDF_ADDR_FEED1 = 8'hc2;
	localparam logic [7:0] WDF_ADDR_FEED2 = 8'hc3;
	// Feed keys
	localparam logic [7:0] WDF_FEED1_KEY = 8'ha5;
	localparam logic [7:0] WDF_FEED2_KEY = 8'h5a;
	// Control field positions
	localparam int unsigned WDF_BIT_OSC = 0;
	localparam int unsigned WDF_BIT_TOF = 1;
	localparam int unsigned WDF_BIT_RUN = 2;
	localparam int unsigned WDF_PRE_LO = 5;
	localparam int unsigned WDF_PRE_HI = 7;
	// Reset values
	localparam logic [7:0] WDF_CTRL_RST = 8'he5;
	localparam logic [7:0] WDF_LOAD_RST = 8'hff;
	// Counter shape and timing counts
	localparam int unsigned WDF_PRE_W = 13;
	localparam int unsigned WDF_CNT_W = 8;
	localparam int unsigned WDF_PRE_BASE = 5;
	localparam logic [1:0] WDF_SW_OLD_TICKS = 2'd2;
	localparam logic [1:0] WDF_SW_NEW_TICKS = 2'd2;

	typedef enum logic [1:0] {SRC_PCLK, SRC_OSC, SRC_XTAL} wdf_src_e;
	typedef enum logic [1:0] {FD_IDLE, FD_ARMED, FD_FIRST} wdf_feed_e;
	typedef enum logic [1:0] {SW_STABLE, SW_DROP, SW_TAKE} wdf_sw_e;

	// Register access from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wdf_sfr_req_s;

	// Configuration bits from outside the block
	typedef struct packed {
		logic reset_on_underflow_enable;
		logic safety_enforce_enable;
		logic crystal_source_select;
		logic int_enable;
	} wdf_cfg_s;
endpackage

// [wdf_clk_sel.sv]
`timescale 1ns/1ps
module wdf_clk_sel
	import wdf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic pclk_tick,
	input wire logic osc_tick,
	input wire logic xtal_tick,
	input wire wdf_src_e req_src,
	input wire logic load,
	output logic wd_tick
);
	typedef struct packed {
		wdf_sw_e ph;
		wdf_src_e cur;
		wdf_src_e pend;
		logic [1:0] cnt;
	} wdf_sel_s;
	wdf_sel_s s_q, s_d;
	logic [2:0] ticks;
	logic old_t, new_t;

	// Tick of current and pending sources
	always_comb begin
		ticks = {xtal_tick, osc_tick, pclk_tick};
		old_t = ticks[s_q.cur];
		new_t = ticks[s_q.pend];
	end

	// Switch sequence, ticks gated while switching
	always_comb begin
		s_d = s_q;
		wd_tick = 1'b0;
		case (s_q.ph)
			SW_STABLE: begin
				wd_tick = old_t;
				if (load && req_src != s_q.cur) begin
					s_d.pend = req_src;
					s_d.ph = SW_DROP;
					s_d.cnt = 2'd0;
				end
			end
			SW_DROP: begin
				if (old_t) s_d.cnt = s_q.cnt + 2'd1;
				if (s_q.cnt == WDF_SW_OLD_TICKS) begin
					s_d.ph = SW_TAKE;
					s_d.cnt = 2'd0;
				end
			end
			SW_TAKE: begin
				if (new_t) s_d.cnt = s_q.cnt + 2'd1;
				if (s_q.cnt == WDF_SW_NEW_TICKS) begin
					s_d.ph = SW_STABLE;
					s_d.cur = s_q.pend;
				end
			end
			default: s_d.ph = SW_STABLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_q <= '{ph: SW_STABLE, cur: SRC_OSC, pend: SRC_OSC, cnt: 2'd0};
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end
endmodule

// [wdf_feed_seq.sv]
`timescale 1ns/1ps
module wdf_feed_seq
	import wdf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clk_en,
	input wire wdf_sfr_req_s req,
	input wire logic wd_mode,
	output logic feed_ok,
	output logic feed_bad
);
	typedef struct packed {
		wdf_feed_e st;
	} wdf_fd_s;
	wdf_fd_s s_q, s_d;
	logic key1, key2;

	// Sequence tracking; reads never disturb it
	always_comb begin
		s_d = s_q;
		feed_ok = 1'b0;
		feed_bad = 1'b0;
		key1 = req.addr == WDF_ADDR_FEED1 && req.wdata == WDF_FEED1_KEY;
		key2 = req.addr == WDF_ADDR_FEED2 && req.wdata == WDF_FEED2_KEY;
		if (req.wr) begin
			case (s_q.st)
				FD_IDLE: begin
					if (key1) begin
						s_d.st = FD_FIRST;
					end else if (req.addr == WDF_ADDR_FEED1 || req.addr == WDF_ADDR_FEED2) begin
						feed_bad = 1'b1;
					end else if (req.addr == WDF_ADDR_CTRL && wd_mode) begin
						s_d.st = FD_ARMED;
					end
				end
				FD_ARMED: begin
					if (key1) begin
						s_d.st = FD_FIRST;
					end else begin
						feed_bad = 1'b1;
						s_d.st = FD_IDLE;
					end
				end
				FD_FIRST: begin
					s_d.st = FD_IDLE;
					if (key2) feed_ok = 1'b1;
					else feed_bad = 1'b1;
				end
				default: s_d.st = FD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_q.st <= FD_IDLE;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end
endmodule

// [wdf_top.sv]
`timescale 1ns/1ps
module wdf_top
	import wdf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clk_en,
	input wire wdf_sfr_req_s sfr_req,
	input wire wdf_cfg_s cfg,
	input wire logic pclk_tick,
	input wire logic osc_tick,
	input wire logic xtal_tick,
	output logic [7:0] sfr_rdata,
	output logic wdt_reset,
	output logic status_flag_clear,
	output logic wdt_irq
);
	typedef struct packed {
		logic [7:0] ctrl_stage;
		logic [7:0] load_stage;
		logic [7:0] ctrl_act;
		logic tof;
		logic [WDF_PRE_W-1:0] pre;
		logic [WDF_CNT_W-1:0] cnt;
		logic uf_pend;
		logic ctrl_once;
		logic load_once;
		logic wd_rst;
		logic flag_clr;
		logic irq;
		logic [7:0] rdata;
	} wdf_top_s;

	localparam wdf_top_s WDF_TOP_RST = '{
		ctrl_stage: WDF_CTRL_RST,
		load_stage: WDF_LOAD_RST,
		ctrl_act: WDF_CTRL_RST,
		tof: 1'b0,
		pre: '0,
		cnt: WDF_LOAD_RST,
		uf_pend: 1'b0,
		ctrl_once: 1'b0,
		load_once: 1'b0,
		wd_rst: 1'b0,
		flag_clr: 1'b0,
		irq: 1'b0,
		rdata: 8'h00
	};

	wdf_top_s s_q, s_d;
	logic wd_mode, safety;
	logic run_eff, osc_eff;
	logic [2:0] tap;
	logic [WDF_PRE_W-1:0] tap_mask;
	logic period_end;
	logic wd_tick;
	logic feed_ok, feed_bad;
	logic wr_ctrl, wr_load;
	logic underflow;
	logic bad_reset;
	logic sub_rst;
	wdf_src_e req_src;
	logic [7:0] ctrl_view;

	// Operating mode from configuration
	always_comb begin
		wd_mode = cfg.reset_on_underflow_enable;
		safety = cfg.reset_on_underflow_enable && cfg.safety_enforce_enable;
	end

	// Effective settings: run and tap from the active control register, clock from the staged one
	always_comb begin
		run_eff = s_q.ctrl_act[WDF_BIT_RUN] || safety;
		osc_eff = s_q.ctrl_stage[WDF_BIT_OSC] || safety; // staged value, taken by the feed
		tap = s_q.ctrl_act[WDF_PRE_HI:WDF_PRE_LO];
	end

	// Source request for the clock selector
	always_comb begin
		if (cfg.crystal_source_select) begin
			req_src = SRC_XTAL;
		end else if (osc_eff) begin
			req_src = SRC_OSC;
		end else begin
			req_src = SRC_PCLK;
		end
	end

	// Submodules also follow the watchdog's own reset
	always_comb begin
		sub_rst = srst || s_q.wd_rst;
	end

	wdf_clk_sel u_clk_sel (
		.clk_sys(clk_sys),
		.srst(sub_rst),
		.clk_en(clk_en),
		.pclk_tick(pclk_tick),
		.osc_tick(osc_tick),
		.xtal_tick(xtal_tick),
		.req_src(req_src),
		.load(feed_ok),
		.wd_tick(wd_tick)
	);

	wdf_feed_seq u_feed_seq (
		.clk_sys(clk_sys),
		.srst(sub_rst),
		.clk_en(clk_en),
		.req(sfr_req),
		.wd_mode(wd_mode),
		.feed_ok(feed_ok),
		.feed_bad(feed_bad)
	);

	// Prescaler tap: period of 2^(5+tap) watchdog clocks
	always_comb begin
		tap_mask = WDF_PRE_W'((14'd1 << (WDF_PRE_BASE + 32'(tap))) - 14'd1);
		period_end = (s_q.pre & tap_mask) == tap_mask;
	end

	// Register write decode
	always_comb begin
		wr_ctrl = 1'b0;
		wr_load = 1'b0;
		if (sfr_req.wr && sfr_req.addr == WDF_ADDR_CTRL) begin
			wr_ctrl = !(safety && s_q.ctrl_once);
		end else if (sfr_req.wr && sfr_req.addr == WDF_ADDR_LOAD) begin
			wr_load = !(safety && s_q.load_once);
		end
	end

	// Control as read back, forced bits shown
	always_comb begin
		ctrl_view = s_q.ctrl_stage;
		ctrl_view[4:3] = 2'b00;
		ctrl_view[WDF_BIT_TOF] = s_q.tof;
		ctrl_view[WDF_BIT_RUN] = s_q.ctrl_stage[WDF_BIT_RUN] || safety;
		ctrl_view[WDF_BIT_OSC] = s_q.ctrl_stage[WDF_BIT_OSC] || safety;
	end

	// Counting, feeds, flags and reset requests
	always_comb begin
		s_d = s_q;
		underflow = 1'b0;
		s_d.wd_rst = 1'b0;
		s_d.flag_clr = 1'b0;

		// Staged writes
		if (wr_ctrl) begin
			s_d.ctrl_stage = sfr_req.wdata;
			s_d.ctrl_once = s_q.ctrl_once || safety;
		end
		if (wr_load) begin
			s_d.load_stage = sfr_req.wdata;
			s_d.load_once = s_q.load_once || safety;
		end

		// Timer mode commits control without a feed
		if (!wd_mode) begin
			s_d.ctrl_act = s_q.ctrl_stage;
		end

		// Down counter driven by the prescaler tap
		if (wd_tick && run_eff) begin
			if (s_q.uf_pend) begin
				underflow = 1'b1;
				s_d.uf_pend = 1'b0;
				s_d.pre = '0;
				s_d.cnt = s_q.load_stage;
			end else if (period_end) begin
				s_d.pre = '0;
				if (s_q.cnt == '0) begin
					s_d.uf_pend = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - 8'd1;
				end
			end else begin
				s_d.pre = s_q.pre + 13'd1;
			end
		end

		// Completed feed commits staged values
		if (feed_ok) begin
			s_d.ctrl_act = s_q.ctrl_stage;
			s_d.cnt = s_q.load_stage;
			s_d.pre = '0;
			s_d.uf_pend = 1'b0;
		end

		// Timeout flag: software zero or watchdog-mode feed clears, underflow wins
		if (wr_ctrl && !sfr_req.wdata[WDF_BIT_TOF]) begin
			s_d.tof = 1'b0;
		end
		if (feed_ok && wd_mode) begin
			s_d.tof = 1'b0;
		end
		if (underflow) begin
			s_d.tof = 1'b1;
		end

		// Interrupt request in timer mode
		s_d.irq = s_d.tof && cfg.int_enable && !wd_mode;

		// Reset on underflow or wrong feed, watchdog mode only
		bad_reset = feed_bad && wd_mode;
		if ((underflow && wd_mode) || bad_reset) begin
			s_d.wd_rst = 1'b1;
			s_d.flag_clr = 1'b1;
		end

		// Register read, answered on the next cycle
		if (sfr_req.rd) begin
			if (sfr_req.addr == WDF_ADDR_CTRL) begin
				s_d.rdata = ctrl_view;
			end else if (sfr_req.addr == WDF_ADDR_LOAD) begin
				s_d.rdata = s_q.load_stage;
			end else begin
				s_d.rdata = 8'h00;
			end
		end

		// Own reset behaves like power-on for the watchdog
		if (s_q.wd_rst) begin
			s_d = WDF_TOP_RST;
		end
	end

	// State register; power-on reset only
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_q <= WDF_TOP_RST;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	always_comb begin
		sfr_rdata = s_q.rdata;
		wdt_reset = s_q.wd_rst;
		status_flag_clear = s_q.flag_clr;
		wdt_irq = s_q.irq;
	end
endmodule

// [wdf_top_chk.sv]
`timescale 1ns/1ps
module wdf_top_chk
	import wdf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire wdf_sfr_req_s sfr_req,
	input wire wdf_cfg_s cfg,
	input wire logic [7:0] sfr_rdata,
	input wire logic wdt_reset,
	input wire logic status_flag_clear,
	input wire logic wdt_irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Decoded mode and bus events
	wire logic wd = cfg.reset_on_underflow_enable;
	wire logic safe = cfg.safety_enforce_enable;
	wire logic wr_ctrl = sfr_req.wr && sfr_req.addr == WDF_ADDR_CTRL;
	wire logic wr_load = sfr_req.wr && sfr_req.addr == WDF_ADDR_LOAD;
	wire logic bad_f2 = sfr_req.wr && sfr_req.addr == WDF_ADDR_FEED2 && sfr_req.wdata != WDF_FEED2_KEY;
	wire logic rd_ctrl = sfr_req.rd && sfr_req.addr == WDF_ADDR_CTRL;

	chk_flag_pair: assert property (status_flag_clear == wdt_reset)
		else $error("flag clear not paired with reset");
	chk_rst_pulse: assert property (wdt_reset |=> !wdt_reset)
		else $error("reset pulse too long");
	chk_bad_feed: assert property (wd && bad_f2 && !wdt_reset && !$past(wdt_reset) |=> wdt_reset)
		else $error("wrong feed gave no reset");
	chk_ctrl_feed: assert property (wd && !safe && wr_ctrl ##1 wr_load |=> wdt_reset)
		else $error("control write not followed by feed kept quiet");
	chk_timer_quiet: assert property ((!wd) [*2] |-> !wdt_reset)
		else $error("reset in timer mode");
	chk_rst_mode: assert property (wdt_reset |-> $past(wd))
		else $error("reset outside watchdog mode");
	chk_irq_cause: assert property (wdt_irq |-> $past(cfg.int_enable && !wd))
		else $error("interrupt without enable in timer mode");
	chk_safe_read: assert property (wd && safe && rd_ctrl |=> sfr_rdata[0] && sfr_rdata[2])
		else $error("forced bits missing");
endmodule

bind wdf_top wdf_top_chk i_chk (.clk_sys(clk_sys), .srst(srst), .sfr_req(sfr_req), .cfg(cfg),
	.sfr_rdata(sfr_rdata), .wdt_reset(wdt_reset), .status_flag_clear(status_flag_clear), .wdt_irq(wdt_irq));

// [wdf_top_bench.sv]
`timescale 1ns/1ps
module wdf_top_bench;
	import wdf_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	wdf_sfr_req_s sfr_req = '0;
	wdf_cfg_s cfg = '0;
	logic pclk_tick = 1'b0;
	logic osc_tick = 1'b0;
	logic xtal_tick = 1'b0;
	logic osc_on = 1'b0;
	logic [31:0] rnd = 32'h2b939ed5;
	logic [7:0] sfr_rdata;
	logic wdt_reset;
	logic status_flag_clear;
	logic wdt_irq;
	logic [2:0] tap;
	logic [7:0] ld;
	int error_cnt = 0;
	int checked = 0;
	int rcnt = 0;
	int fcnt = 0;
	int n;
	int t;
	int r0;

	wdf_top i_dut (.clk_sys(clk_sys), .srst(srst), .clk_en(1'b1), .sfr_req(sfr_req), .cfg(cfg),
		.pclk_tick(pclk_tick), .osc_tick(osc_tick), .xtal_tick(xtal_tick), .sfr_rdata(sfr_rdata),
		.wdt_reset(wdt_reset), .status_flag_clear(status_flag_clear), .wdt_irq(wdt_irq));

	always #20 clk_sys = ~clk_sys;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected timeout in source ticks
	function automatic int tclks(input logic [2:0] p, input logic [7:0] l);
		return (1 << (5 + p)) * (l + 1) + 1;
	endfunction

	// Source ticks; peripheral clock and crystal toggle at random, oscillator follows osc_on
	always @(negedge clk_sys) begin
		rnd <= lfsr(rnd);
		pclk_tick <= rnd[0];
		xtal_tick <= rnd[1];
		osc_tick <= osc_on;
	end

	// Count watchdog reset pulses
	always @(posedge clk_sys) if (wdt_reset === 1'b1) rcnt <= rcnt + 1;

	// Count flag clear pulses
	always @(posedge clk_sys) if (status_flag_clear === 1'b1) fcnt <= fcnt + 1;

	task automatic results();
		$display("Checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %0h, want %0h", $time, seen, exp);
		end
	endtask

	task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_req = '{wr: w, rd: r, addr: a, wdata: d};
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, 1'b0, a, d);
	endtask

	task automatic idle();
		acc(1'b0, 1'b0, 8'h00, 8'h00);
	endtask

	task automatic feed();
		wr(WDF_ADDR_FEED1, WDF_FEED1_KEY);
		wr(WDF_ADDR_FEED2, WDF_FEED2_KEY);
		idle();
	endtask

	task automatic rd_ctrl(input logic [7:0] exp);
		acc(1'b0, 1'b1, WDF_ADDR_CTRL, 8'h00);
		idle();
		@(negedge clk_sys);
		check(sfr_rdata, exp);
	endtask

	task automatic do_reset(input logic [3:0] c);
		@(negedge clk_sys);
		srst = 1'b1;
		cfg = c;
		repeat (16) @(negedge clk_sys);
		srst = 1'b0;
	endtask

	// Wait for an interrupt or a new reset pulse, bounded
	task automatic wait_ev(input logic irq_mode, output int cnt);
		int r;
		r = rcnt;
		cnt = 0;
		while ((irq_mode ? wdt_irq !== 1'b1 : rcnt == r) && cnt < 3000) begin
			@(negedge clk_sys);
			cnt++;
		end
		if (cnt >= 3000) begin
			error_cnt++;
			$display("Error at %0t: wait timed out", $time);
			results();
		end
	endtask

	// Main sequence
	initial begin
		do_reset(4'b0001);
		rd_ctrl(8'he5);
		for (int k = 0; k < 4; k++) begin
			tap = (k == 0) ? 3'd0 : {2'b00, rnd[0]};
			ld = (k == 0) ? 8'd0 : {5'd0, rnd[4:2]};
			t = tclks(tap, ld);
			wr(WDF_ADDR_LOAD, ld);
			wr(WDF_ADDR_CTRL, {tap, 5'b00101});
			feed();
			osc_on <= 1'b1;
			check(wdt_irq, 1'b0);
			wait_ev(1'b1, n);
			check(n >= t && n <= t + 4, 1'b1);
			wr(WDF_ADDR_CTRL, {tap, 5'b00101});
			idle();
			@(negedge clk_sys);
			check(wdt_irq, 1'b0);
			wait_ev(1'b1, n);
			check(n <= t + 4, 1'b1);
			osc_on <= 1'b0;
		end
		wr(WDF_ADDR_CTRL, 8'h01);
		idle();
		osc_on <= 1'b1;
		repeat (600) @(negedge clk_sys);
		check(wdt_irq, 1'b0);
		osc_on <= 1'b0;
		r0 = rcnt;
		wr(WDF_ADDR_FEED2, 8'h00);
		idle();
		repeat (3) @(negedge clk_sys);
		check(rcnt, r0);
		$display("Done: timer mode");
		do_reset(4'b1000);
		wr(WDF_ADDR_LOAD, 8'h00);
		wr(WDF_ADDR_CTRL, 8'h05);
		feed();
		osc_on <= 1'b1;
		wait_ev(1'b0, n);
		check(n >= 33 && n <= 37, 1'b1);
		osc_on <= 1'b0;
		repeat (3) @(negedge clk_sys);
		rd_ctrl(8'he5);
		wr(WDF_ADDR_FEED1, WDF_FEED1_KEY);
		wr(WDF_ADDR_FEED2, 8'h5b);
		idle();
		wait_ev(1'b0, n);
		check(n <= 3, 1'b1);
		repeat (3) @(negedge clk_sys);
		wr(WDF_ADDR_CTRL, 8'h05);
		wr(WDF_ADDR_LOAD, 8'h00);
		idle();
		wait_ev(1'b0, n);
		check(n <= 3, 1'b1);
		repeat (3) @(negedge clk_sys);
		$display("Done: watchdog mode");
		// Source switch after a feed: peripheral clock, then crystal; old source stops after 3 ticks
		for (int m = 0; m < 2; m++) begin
			do_reset((m == 1) ? 4'b0011 : 4'b1000);
			wr(WDF_ADDR_LOAD, 8'h00);
			wr(WDF_ADDR_CTRL, (m == 1) ? 8'h25 : 8'h24);
			feed();
			osc_on <= 1'b1;
			repeat (3) @(negedge clk_sys);
			osc_on <= 1'b0;
			t = tclks(3'd1, 8'd0);
			wait_ev(m == 1, n);
			check(n >= t && n <= 4 * t + 8, 1'b1);
		end
		check(fcnt, rcnt);
		$display("Done: clock sources");
		do_reset(4'b1100);
		wr(WDF_ADDR_CTRL, 8'h20);
		feed();
		rd_ctrl(8'h25);
		wr(WDF_ADDR_CTRL, 8'h40);
		feed();
		rd_ctrl(8'h25);
		$display("Done: safety mode");
		results();
	end
endmodule
